// ### hdl/bofe_pkg.sv
// Shared constants and carrier types of the bit-oriented frame engine.
// Assumes a single 10 MHz clock and a synchronous active-high reset.
package bofe_pkg;
    // ========================================
    // Line patterns and counts
    localparam logic [7:0]  FLAG_PATTERN  = 8'h7E;
    localparam logic [7:0]  ABORT_PATTERN = 8'hFE;
    localparam int          STUFF_RUN     = 5;
    localparam int          ABORT_RUN     = 7;
    localparam int          IDLE_RUN      = 15;
    localparam int          RX_FIFO_DEPTH = 32;
    localparam int          TX_FIFO_DEPTH = 16;
    localparam int          MAX_PACKET    = 65535;
    // ========================================
    // Check sequence
    localparam logic [15:0] CRC_POLY_REV  = 16'h8408;
    localparam logic [15:0] CRC_PRESET    = 16'hFFFF;
    localparam logic [15:0] CRC_GOOD      = 16'hF0B8;
    // ========================================
    // Carriers
    typedef struct packed {
        logic [7:0] data;
        logic       last;
    } bofe_byte_t;

    typedef struct packed {
        logic       frame_ok;
        logic       crc_error;
        logic       aborted;
        logic       short_frame;
        logic       long_frame;
    } bofe_rx_status_t;

    typedef enum logic [2:0] {
        TX_IDLE,
        TX_OPEN,
        TX_DATA,
        TX_CRC,
        TX_CLOSE,
        TX_ABORT
    } bofe_tx_state_t;

    function automatic logic [15:0] bofe_crc_step(input logic [15:0] crc, input logic bit_in);
        logic fb;
        fb = crc[0] ^ bit_in;
        bofe_crc_step = fb ? ((crc >> 1) ^ CRC_POLY_REV) : (crc >> 1);
    endfunction
endpackage

// ### hdl/bofe_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; width and depth set by parameters.
`timescale 1ns/1ns
module bofe_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             srst_in,
    // Fill side
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    // Drain side
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic [WIDTH-1:0]      out_data_out,
    input  wire logic             flush_in
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    assign in_ready_out  = (count != (AW+1)'(DEPTH));
    assign out_valid_out = (count != '0);
    assign out_data_out  = mem[rd_ptr];
    assign push          = in_valid_in && in_ready_out;
    assign pop           = out_valid_out && out_ready_in;

    // ========================================
    // Storage
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[wr_ptr] <= in_data_in;
        end
    end

    // ========================================
    // Pointers, flush wins
    always_ff @(posedge clk_in) begin
        if (srst_in || flush_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    fifo_bound_a: assert property (@(posedge clk_in) disable iff (srst_in)
        count <= (AW+1)'(DEPTH)) else $error("fifo count past depth");
endmodule

// ### hdl/bofe_crc.sv
// Bit-serial CCITT check sequence engine, LSB-first reflected form.
// Assumes the caller strobes only unstuffed packet bits.
`timescale 1ns/1ns
module bofe_crc (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        srst_in,
    // Control
    input  wire logic        init_in,
    input  wire logic        bit_valid_in,
    input  wire logic        bit_in,
    // Result
    output logic [15:0]      crc_out
);
    import bofe_pkg::*;

    // ========================================
    // Shift register, preset to all ones
    always_ff @(posedge clk_in) begin
        if (srst_in || init_in) begin
            crc_out <= CRC_PRESET;
        end else if (bit_valid_in) begin
            crc_out <= bofe_crc_step(crc_out, bit_in);
        end
    end

    crc_preset_a: assert property (@(posedge clk_in) disable iff (srst_in)
        init_in |=> crc_out == 16'hFFFF) else $error("crc not preset");
endmodule

// ### hdl/bofe_engine.sv
// Top of the bit-oriented frame engine: serial transmit and receive paths.
// Assumes line bits are synchronous to clk_in with a one-cycle bit strobe.
`timescale 1ns/1ns
module bofe_engine #(
    parameter int ADDR_LEN = 2,
    parameter int CTRL_LEN = 1
) (
    // Clock and reset
    input  wire logic                      clk_in,
    input  wire logic                      srst_in,
    // Configuration
    input  wire logic                      flag_fill_idle_in,
    input  wire logic                      ea_check_in,
    input  wire logic                      send_abort_in,
    // Transmit bus side (processor or DMA)
    input  wire logic                      tx_valid_in,
    input  wire bofe_pkg::bofe_byte_t      tx_byte_in,
    output logic                           tx_ready_out,
    // Receive bus side (processor or DMA)
    output logic                           rx_valid_out,
    output bofe_pkg::bofe_byte_t           rx_byte_out,
    input  wire logic                      rx_ready_in,
    // Serial line port
    input  wire logic                      bit_strobe_in,
    input  wire logic                      line_rx_in,
    output logic                           line_tx_out,
    // Status
    output logic                           tx_in_frame_out,
    output logic                           rx_in_frame_out,
    output logic                           ones_idle_out,
    output bofe_pkg::bofe_rx_status_t      rx_status_out,
    output logic                           rx_status_valid_out
);
    import bofe_pkg::*;

    // ========================================
    // Transmit FIFO
    logic       txf_valid;
    logic       txf_ready;
    logic [8:0] txf_data;
    logic       txf_ready_in;

    bofe_fifo #(.WIDTH(9), .DEPTH(TX_FIFO_DEPTH)) u_tx_fifo (
        .clk_in        (clk_in),
        .srst_in       (srst_in),
        .in_valid_in   (tx_valid_in && tx_ready_out),
        .in_ready_out  (txf_ready_in),
        .in_data_in    (tx_byte_in),
        .out_valid_out (txf_valid),
        .out_ready_in  (txf_ready),
        .out_data_out  (txf_data),
        .flush_in      (1'b0)
    );

    always_ff @(posedge clk_in) begin
        // Drops for one cycle after each accepted byte, so a registered ready never overstates room
        tx_ready_out <= srst_in ? 1'b0 : txf_ready_in && !(tx_valid_in && tx_ready_out);
    end

    // ========================================
    // Transmit sequencer
    bofe_tx_state_t tx_state;
    logic [7:0]  tx_shift;
    logic [2:0]  tx_bit;
    logic [2:0]  tx_ones;
    logic        tx_last;
    logic [15:0] tx_crc;
    logic [3:0]  tx_crc_bit;
    logic        tx_stuff_now;
    logic        tx_data_bit;
    logic        abort_pend;

    assign tx_stuff_now = (tx_ones == 3'(STUFF_RUN));
    assign tx_data_bit  = (tx_state == TX_CRC) ? ~tx_crc[tx_crc_bit] : tx_shift[tx_bit];

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            abort_pend <= 1'b0;
        end else if (send_abort_in && tx_state != TX_IDLE) begin
            abort_pend <= 1'b1;
        end else if (tx_state == TX_ABORT || tx_state == TX_IDLE) begin
            abort_pend <= 1'b0;
        end
    end

    logic tx_pop;
    assign tx_pop = bit_strobe_in && txf_valid && (
        (tx_state == TX_OPEN && tx_bit == 3'd7) ||
        (tx_state == TX_DATA && !tx_stuff_now && tx_bit == 3'd7 && !tx_last));
    assign txf_ready = tx_pop && !abort_pend;

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            tx_state    <= TX_IDLE;
            tx_shift    <= 8'hFF;
            tx_bit      <= 3'd0;
            tx_ones     <= 3'd0;
            tx_last     <= 1'b0;
            tx_crc      <= CRC_PRESET;
            tx_crc_bit  <= 4'd0;
            line_tx_out <= 1'b1;
        end else if (bit_strobe_in) begin
            case (tx_state)
                TX_IDLE: begin
                    line_tx_out <= flag_fill_idle_in ? FLAG_PATTERN[tx_bit] : 1'b1;
                    tx_bit      <= tx_bit + 3'd1;
                    if (tx_bit == 3'd7 && txf_valid) begin
                        tx_state <= TX_OPEN;
                    end
                end
                TX_OPEN: begin
                    line_tx_out <= FLAG_PATTERN[tx_bit];
                    tx_bit      <= tx_bit + 3'd1;
                    tx_crc      <= CRC_PRESET;
                    tx_ones     <= 3'd0;
                    if (tx_bit == 3'd7) begin
                        tx_shift <= txf_data[8:1];
                        tx_last  <= txf_data[0];
                        tx_state <= TX_DATA;
                    end
                end
                TX_DATA, TX_CRC: begin
                    if (abort_pend) begin
                        tx_state <= TX_ABORT;
                        tx_bit   <= 3'd0;
                    end else if (tx_stuff_now) begin
                        line_tx_out <= 1'b0;
                        tx_ones     <= 3'd0;
                    end else begin
                        line_tx_out <= tx_data_bit;
                        tx_ones     <= tx_data_bit ? tx_ones + 3'd1 : 3'd0;
                        if (tx_state == TX_DATA) begin
                            tx_crc <= bofe_crc_step(tx_crc, tx_data_bit);
                            tx_bit <= tx_bit + 3'd1;
                            if (tx_bit == 3'd7) begin
                                if (tx_last || !txf_valid) begin
                                    tx_state   <= TX_CRC;
                                    tx_crc_bit <= 4'd0;
                                end else begin
                                    tx_shift <= txf_data[8:1];
                                    tx_last  <= txf_data[0];
                                end
                            end
                        end else begin
                            tx_crc_bit <= tx_crc_bit + 4'd1;
                            if (tx_crc_bit == 4'd15) begin
                                tx_state <= TX_CLOSE;
                                tx_bit   <= 3'd0;
                            end
                        end
                    end
                end
                TX_CLOSE: begin
                    line_tx_out <= tx_stuff_now ? 1'b0 : FLAG_PATTERN[tx_bit];
                    tx_ones     <= 3'd0;
                    tx_bit      <= tx_stuff_now ? tx_bit : tx_bit + 3'd1;
                    if (tx_bit == 3'd7 && !tx_stuff_now) begin
                        tx_state <= TX_IDLE;
                    end
                end
                TX_ABORT: begin
                    line_tx_out <= ABORT_PATTERN[tx_bit];
                    tx_bit      <= tx_bit + 3'd1;
                    if (tx_bit == 3'd7) begin
                        tx_state <= TX_IDLE;
                    end
                end
                default: tx_state <= TX_IDLE;
            endcase
        end
    end

    // Abort frames leave the rest of the packet in the FIFO; it goes out as the next frame

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            tx_in_frame_out <= 1'b0;
        end else begin
            tx_in_frame_out <= tx_state inside {TX_OPEN, TX_DATA, TX_CRC, TX_CLOSE} && !abort_pend;
        end
    end

    tx_stuff_a: assert property (@(posedge clk_in) disable iff (srst_in)
        bit_strobe_in && tx_stuff_now && (tx_state == TX_DATA || tx_state == TX_CRC) && !abort_pend
        |=> !line_tx_out) else $error("missing stuffed zero");

    // ========================================
    // Receive line side: run detection and destuffing
    logic [7:0]  rx_win;
    logic [3:0]  rx_ones;
    logic        rx_flag;
    logic        rx_abort;
    logic        rx_stuffed;

    assign rx_flag    = ({line_rx_in, rx_win[7:1]} == FLAG_PATTERN);
    assign rx_abort   = line_rx_in && rx_ones >= 4'(ABORT_RUN - 1);
    assign rx_stuffed = !line_rx_in && rx_ones == 4'(STUFF_RUN);

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rx_win        <= 8'h00;
            rx_ones       <= 4'd0;
            ones_idle_out <= 1'b0;
        end else if (bit_strobe_in) begin
            rx_win        <= {line_rx_in, rx_win[7:1]};
            rx_ones       <= line_rx_in ? ((rx_ones == 4'd15) ? rx_ones : rx_ones + 4'd1) : 4'd0;
            ones_idle_out <= line_rx_in && rx_ones >= 4'(IDLE_RUN - 1);
        end
    end

    // ========================================
    // Receive framing
    logic        rx_flag_seen;
    logic        rx_in_frame;
    logic [7:0]  rx_shift;
    logic [3:0]  rx_nbits;
    logic [16:0] rx_bytes;
    logic        rx_addr_done;
    logic [16:0] rx_min;
    logic        rxf_valid_in;
    logic        rxf_ready_in;
    logic [8:0]  rxf_data;
    logic [15:0] rx_crc;
    logic        rx_crc_init;
    logic        rx_crc_en;
    logic        rx_end;
    logic [15:0] rx_crc_snap;
    logic [15:0] rx_hold;

    assign rx_min      = 17'(ADDR_LEN + CTRL_LEN + 2);
    assign rx_crc_en   = bit_strobe_in && !rx_flag && !rx_abort && !rx_stuffed && (rx_flag_seen || rx_in_frame);
    assign rx_crc_init = bit_strobe_in && rx_flag;
    assign rx_end      = bit_strobe_in && rx_in_frame && (rx_flag || rx_abort);

    bofe_crc u_rx_crc (
        .clk_in       (clk_in),
        .srst_in      (srst_in),
        .init_in      (rx_crc_init),
        .bit_valid_in (rx_crc_en),
        .bit_in       (line_rx_in),
        .crc_out      (rx_crc)
    );

    // Flags only seen on the line side, so a flag closes rather than loads data bits
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rx_flag_seen <= 1'b0;
            rx_in_frame  <= 1'b0;
            rx_shift     <= 8'h00;
            rx_nbits     <= 4'd0;
            rx_bytes     <= 17'd0;
            rx_addr_done <= 1'b0;
            rxf_valid_in <= 1'b0;
            rxf_data     <= 9'h000;
            rx_hold      <= 16'h0000;
            rx_crc_snap  <= CRC_PRESET;
        end else begin
            rxf_valid_in <= 1'b0;
            if (bit_strobe_in) begin
                if (rx_abort) begin
                    rx_flag_seen <= 1'b0;
                    rx_in_frame  <= 1'b0;
                end else if (rx_flag) begin
                    rx_flag_seen <= 1'b1;
                    rx_in_frame  <= 1'b0;
                    rx_nbits     <= 4'd0;
                    rx_bytes     <= 17'd0;
                    rx_addr_done <= 1'b0;
                    rx_crc_snap  <= CRC_PRESET;
                end else if (!rx_stuffed && (rx_flag_seen || rx_in_frame)) begin
                    rx_shift <= {line_rx_in, rx_shift[7:1]};
                    rx_nbits <= (rx_nbits == 4'd7) ? 4'd0 : rx_nbits + 4'd1;
                    if (rx_nbits == 4'd7) begin
                        rx_in_frame  <= 1'b1;
                        rx_flag_seen <= 1'b0;
                        rx_bytes     <= rx_bytes + 17'd1;
                        rx_crc_snap  <= bofe_crc_step(rx_crc, line_rx_in);
                        rx_hold      <= {line_rx_in, rx_shift[7:1], rx_hold[15:8]};
                        if (!rx_addr_done && (!ea_check_in || rx_shift[1])) begin
                            rx_addr_done <= 1'b1;
                        end
                        if (rx_bytes >= 17'd2) begin
                            rxf_valid_in <= 1'b1;
                            rxf_data     <= {rx_hold[7:0], 1'b0};
                        end
                    end
                end
            end
        end
    end

    // ========================================
    // End-of-frame status
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rx_status_out       <= '0;
            rx_status_valid_out <= 1'b0;
        end else begin
            rx_status_valid_out <= rx_end;
            if (rx_end) begin
                rx_status_out.aborted     <= rx_abort;
                rx_status_out.short_frame <= !rx_abort && rx_bytes < rx_min;
                rx_status_out.long_frame  <= rx_bytes > 17'(MAX_PACKET);
                rx_status_out.crc_error   <= !rx_abort && rx_crc_snap != CRC_GOOD;
                rx_status_out.frame_ok    <= !rx_abort && rx_crc_snap == CRC_GOOD && rx_bytes >= rx_min
                                             && rx_addr_done;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        rx_in_frame_out <= srst_in ? 1'b0 : rx_in_frame;
    end

    // ========================================
    // Receive FIFO; writes lag the line by two bytes, so the two trailing check bytes never enter it
    bofe_fifo #(.WIDTH(9), .DEPTH(RX_FIFO_DEPTH)) u_rx_fifo (
        .clk_in        (clk_in),
        .srst_in       (srst_in),
        .in_valid_in   (rxf_valid_in),
        .in_ready_out  (rxf_ready_in),
        .in_data_in    (rxf_data),
        .out_valid_out (rx_valid_out),
        .out_ready_in  (rx_ready_in),
        .out_data_out  (rx_byte_out),
        .flush_in      (1'b0)
    );

    rx_abort_a: assert property (@(posedge clk_in) disable iff (srst_in)
        bit_strobe_in && rx_in_frame && rx_abort |=> !rx_in_frame) else $error("abort kept frame");
    rx_close_a: assert property (@(posedge clk_in) disable iff (srst_in)
        rx_end |=> rx_status_valid_out ##1 !rx_in_frame_out) else $error("close not reported");
    crc_report_a: assert property (@(posedge clk_in) disable iff (srst_in)
        rx_end && !rx_abort && rx_crc_snap != CRC_GOOD |=> rx_status_out.crc_error) else $error("crc error lost");
    idle_ones_a: assert property (@(posedge clk_in) disable iff (srst_in)
        tx_state == TX_IDLE && !flag_fill_idle_in && bit_strobe_in |=> line_tx_out) else $error("idle not ones");
    abort_send_a: assert property (@(posedge clk_in) disable iff (srst_in)
        bit_strobe_in && tx_state == TX_ABORT && tx_bit != 3'd0 |=> line_tx_out) else $error("abort bits wrong");
    tx_frame_a: assert property (@(posedge clk_in) disable iff (srst_in)
        tx_state == TX_OPEN && !abort_pend |=> tx_in_frame_out) else $error("tx in-frame late");
    seven_ones_a: assert property (@(posedge clk_in) disable iff (srst_in)
        bit_strobe_in && line_rx_in && rx_ones == 4'd6 |-> rx_abort) else $error("abort missed");
endmodule

// ### verif/bofe_far_end.sv
// Far-end station model: sends stuffed frames on the receive line, or echoes the engine's line.
// Assumes bench bit strobes at least two clocks apart; the line idles high.
`timescale 1ns/1ns
module bofe_far_end (
    // Clock and strobe
    input  wire logic clk_in,
    input  wire logic bit_strobe_in,
    // Line
    input  wire logic line_tx_in,
    input  wire logic echo_in,
    output logic      line_rx_out
);
    // ========================================
    // Bit queue; an empty queue leaves the line marking
    logic        q[$];
    logic        held = 1'b1;
    logic [15:0] crc;
    int          ones;
    always @(posedge clk_in) if (bit_strobe_in) held <= (q.size() > 0) ? q.pop_front() : 1'b1;
    assign line_rx_out = echo_in ? line_tx_in : held;

    // ========================================
    // Byte, LSB first, with optional stuffing and CRC update
    task automatic put(input logic [7:0] b, input bit stuff, input bit no_crc);
        for (int i = 0; i < 8; i++) begin
            q.push_back(b[i]);
            if (!no_crc) crc = (crc >> 1) ^ ((crc[0] ^ b[i]) ? 16'h8408 : 16'h0000);
            ones = (b[i] && stuff) ? ones + 1 : 0;
            if (ones == 5) begin
                q.push_back(1'b0);
                ones = 0;
            end
        end
    endtask

    // Mode 0 good, 1 corrupt check, 2 abort after data
    task automatic send_frame(input logic [7:0] d[$], input int mode);
        logic [15:0] f;
        crc = 16'hFFFF;
        ones = 0;
        put(8'h7E, 0, 1);
        put(8'h7E, 0, 1);
        foreach (d[i]) put(d[i], 1, 0);
        f = ~crc ^ {15'h0000, mode == 1};
        if (mode == 2) begin
            put(8'hFE, 0, 1);
            put(8'hFE, 0, 1);
        end else begin
            put(f[7:0], 1, 1);
            put(f[15:8], 1, 1);
            put(8'h7E, 0, 1);
        end
    endtask
endmodule

// ### verif/bofe_engine_tb_top.sv
// Self-checking bench for the frame engine, with a far-end model on the line.
// Assumes a 10 MHz clock and a bit strobe every fourth clock.
`timescale 1ns/1ns
module bofe_engine_tb_top;
    import bofe_pkg::*;
    // ========================================
    // Signals
    logic clk_in, srst_in, flag_fill_idle_in, ea_check_in, send_abort_in, tx_valid_in, rx_ready_in;
    logic bit_strobe_in, line_rx_in, line_tx_out, tx_ready_out, rx_valid_out, echo;
    logic tx_in_frame_out, rx_in_frame_out, ones_idle_out, rx_status_valid_out;
    bofe_byte_t      tx_byte_in, rx_byte_out;
    bofe_rx_status_t rx_status_out, st;
    logic [7:0]      got[$], d[$];
    logic [15:0]     hist;
    int              fails, n_compared, cyc, sp, nst, refused;

    bofe_engine dut (.clk_in(clk_in), .srst_in(srst_in), .flag_fill_idle_in(flag_fill_idle_in),
        .ea_check_in(ea_check_in), .send_abort_in(send_abort_in), .tx_valid_in(tx_valid_in),
        .tx_byte_in(tx_byte_in), .tx_ready_out(tx_ready_out), .rx_valid_out(rx_valid_out),
        .rx_byte_out(rx_byte_out), .rx_ready_in(rx_ready_in), .bit_strobe_in(bit_strobe_in),
        .line_rx_in(line_rx_in), .line_tx_out(line_tx_out), .tx_in_frame_out(tx_in_frame_out),
        .rx_in_frame_out(rx_in_frame_out), .ones_idle_out(ones_idle_out),
        .rx_status_out(rx_status_out), .rx_status_valid_out(rx_status_valid_out));
    bofe_far_end far (.clk_in(clk_in), .bit_strobe_in(bit_strobe_in), .line_tx_in(line_tx_out),
        .echo_in(echo), .line_rx_out(line_rx_in));

    // ========================================
    // Clock, strobe, monitors and hang guard
    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        sp <= (sp == 3) ? 0 : sp + 1;
        bit_strobe_in <= (sp == 2);
        if (rx_valid_out && rx_ready_in) got.push_back(rx_byte_out.data);
        if (rx_status_valid_out) st <= rx_status_out;
        if (rx_status_valid_out) nst <= nst + 1;
        if (bit_strobe_in) hist <= {hist[14:0], line_tx_out};
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            fails++;
            tally_and_finish();
        end
    end

    // ========================================
    // Shared tasks
    task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic wait_st(input int n0);
        for (int k = 0; k < 6000 && nst == n0; k++) @(posedge clk_in);
        repeat (40) @(posedge clk_in);
        #1 rx_ready_in = 1'b1;
        repeat (80) @(posedge clk_in);
        #1;
    endtask
    // Receive stalled until the status arrives, then drained
    task automatic rx_case(input string w, input int mode, input logic [4:0] e, input bit cmp);
        int n0;
        n0 = nst;
        got.delete();
        rx_ready_in = 1'b0;
        far.send_frame(d, mode);
        wait_st(n0);
        chk({w, " status"}, e, st);
        chk({w, " rx out of frame"}, 0, rx_in_frame_out);
        if (cmp) chk({w, " count"}, d.size(), got.size());
        if (cmp) foreach (d[i]) chk({w, " byte"}, d[i], got[i]);
        $display("test %s done", w);
    endtask

    // ========================================
    // Scenarios
    task automatic t_idle;
        repeat (160) @(posedge clk_in);
        chk("mark idle line", 16'hFFFF, hist);
        chk("ones idle", 1, ones_idle_out);
        #1 flag_fill_idle_in = 1'b1;
        repeat (160) @(posedge clk_in);
        chk("flag period", hist[15:8], hist[7:0]);
        chk("flag ones", 6, $countones(hist[7:0]));
        chk("ones idle off", 0, ones_idle_out);
        $display("test idle done");
    endtask
    task automatic t_rx;
        echo = 1'b0;
        d = '{8'h02, 8'h01, 8'h3F, 8'hFF, 8'h7E};
        rx_case("rx good", 0, 5'b10000, 1);
        rx_case("rx bad check", 1, 5'b01000, 0);
        rx_case("rx abort", 2, 5'b00100, 0);
        d = '{8'h01};
        rx_case("rx short", 0, 5'b00010, 0);
    endtask
    // Loop back: 20 bytes overfill the 16-word buffer, then come back intact unless an abort is sent
    task automatic t_tx(input int abort_at);
        int n0;
        bit acc;
        n0 = nst;
        refused = 0;
        echo = 1'b1;
        d.delete();
        for (int i = 0; i < 20; i++) d.push_back(8'(i * 37 + 5));
        got.delete();
        foreach (d[i]) begin
            tx_valid_in = 1'b1;
            tx_byte_in = '{data: d[i], last: i == 19};
            for (int k = 0; k < 2000; k++) begin
                acc = tx_ready_out;
                @(posedge clk_in);
                #1;
                if (acc) break;
                if (k == 4) refused++;
            end
        end
        tx_valid_in = 1'b0;
        chk("tx in frame", 1, tx_in_frame_out);
        chk("tx refused when full", 1, refused > 0);
        if (abort_at < 20) send_abort_in = 1'b1;
        @(posedge clk_in);
        #1 send_abort_in = 1'b0;
        wait_st(n0);
        chk("loop status", abort_at < 20 ? 5'b00100 : 5'b10000, st);
        if (abort_at > 19) chk("loop count", 20, got.size());
        if (abort_at > 19) foreach (d[i]) chk("loop byte", d[i], got[i]);
        if (abort_at > 19) chk("tx out of frame", 0, tx_in_frame_out);
        $display("test loop done");
    endtask

    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    initial begin
        {flag_fill_idle_in, send_abort_in, tx_valid_in, bit_strobe_in, echo} = '0;
        {fails, n_compared, cyc, sp, nst} = '0;
        {srst_in, ea_check_in, rx_ready_in} = 3'b111;
        tx_byte_in = '0;
        echo = 1'b1;
        repeat (3) @(posedge clk_in);
        #1 srst_in = 1'b0;
        t_idle();
        t_rx();
        t_tx(99);
        t_tx(17);
        tally_and_finish();
    end
endmodule
